// ---- rtl/eedac_ctrl.v ----
// data eeprom access controller: registers, array, read and write sequencing, interrupt flags
`timescale 1ns/1ps
`include "eedac_regs.vh"
module eedac_ctrl #(
    parameter ADDR_W    = `EEDAC_ADDR_W,
    parameter DEPTH     = `EEDAC_DEPTH,
    parameter RD_CYCLES = `EEDAC_RD_CYCLES
) (
    input  wire       ref_clk,
    input  wire       rst,
    input  wire       cpuWrEn,
    input  wire [7:0] cpuAddr,
    input  wire [1:0] bankSelect,
    input  wire [7:0] cpuWrData,
    output reg  [7:0] nvmAddressReg,
    output reg  [7:0] nvmDataReg,
    output reg  [7:0] nvmControlReg,
    output reg        timerStart,
    output reg  [5:0] timerAddr,
    output reg  [7:0] timerData,
    input  wire       timerDone,
    input  wire       eepromIrqEnable,
    input  wire       mfIrqEnable,
    input  wire       globalIrqEnable,
    input  wire       stackFull,
    input  wire       irqAck,
    input  wire       eepromIrqClear,
    output reg        eepromIrqRequest,
    output reg        mfIrqRequest,
    output reg        irqVector
);
    localparam ST_IDLE  = 2'h0;
    localparam ST_READ  = 2'h1;
    localparam ST_WRITE = 2'h2;
    localparam ST_WDONE = 2'h3;

    reg  [7:0]        mem [0:DEPTH-1];
    reg  [1:0]        state_q;
    reg  [3:0]        rdCnt_q;
    reg               doneSeen_q;
    wire              doneSync;
    wire              selAddr;
    wire              selData;
    wire              selCtrl;
    wire              wrDone;
    wire              busy;
    wire [ADDR_W-1:0] memIdx;

    eedac_sync u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .asyncIn (timerDone),
        .syncOut (doneSync)
    );

    assign selAddr = cpuWrEn && (bankSelect == `EEDAC_REG_BANK) && (cpuAddr == `EEDAC_ADDR_OFS);
    assign selData = cpuWrEn && (bankSelect == `EEDAC_REG_BANK) && (cpuAddr == `EEDAC_DATA_OFS);
    assign selCtrl = cpuWrEn && (bankSelect == `EEDAC_CTRL_BANK) && (cpuAddr == `EEDAC_CTRL_OFS);
    assign memIdx  = nvmAddressReg[ADDR_W-1:0];
    // a start still waiting for the sequencer counts too, so a quick rewrite cannot cancel it
    assign busy    = (state_q != ST_IDLE) || nvmControlReg[`EEDAC_BIT_WRSTART] ||
                     nvmControlReg[`EEDAC_BIT_RDSTART];
    assign wrDone  = (state_q == ST_WDONE) && doneSync && !doneSeen_q;

    ////////////////////////////////////////////////////////////////////////
    // array write; only the sequencer touches it
    // latched copies, so a later address change cannot move the cell mid-write
    always @(posedge ref_clk) begin
        if (wrDone) begin
            mem[timerAddr] <= timerData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q       <= ST_IDLE;
            rdCnt_q       <= 4'h0;
            doneSeen_q    <= 1'b0;
            nvmAddressReg <= `EEDAC_RST_BYTE;
            nvmDataReg    <= `EEDAC_RST_BYTE;
            nvmControlReg <= `EEDAC_RST_BYTE;
            timerStart    <= 1'b0;
            timerAddr     <= 6'h00;
            timerData     <= 8'h00;
        end else begin
            timerStart <= 1'b0;
            doneSeen_q <= doneSync;
            if (selAddr) begin
                nvmAddressReg <= {{(8-ADDR_W){1'b0}}, cpuWrData[ADDR_W-1:0]};
            end
            // data register frozen while a write is in flight
            if (selData && !busy) begin
                nvmDataReg <= cpuWrData;
            end
            if (selCtrl) begin
                nvmControlReg[7:4] <= 4'h0;
                nvmControlReg[`EEDAC_BIT_WRPERMIT] <= cpuWrData[`EEDAC_BIT_WRPERMIT];
                nvmControlReg[`EEDAC_BIT_RDPERMIT] <= cpuWrData[`EEDAC_BIT_RDPERMIT];
                if (!busy) begin
                    nvmControlReg[`EEDAC_BIT_WRSTART] <= cpuWrData[`EEDAC_BIT_WRSTART] &&
                                                         nvmControlReg[`EEDAC_BIT_WRPERMIT] &&
                                                         !cpuWrData[`EEDAC_BIT_RDSTART];
                    nvmControlReg[`EEDAC_BIT_RDSTART] <= cpuWrData[`EEDAC_BIT_RDSTART] &&
                                                         nvmControlReg[`EEDAC_BIT_RDPERMIT] &&
                                                         !cpuWrData[`EEDAC_BIT_WRSTART];
                end
            end
            case (state_q)
                ST_IDLE: begin
                    if (nvmControlReg[`EEDAC_BIT_WRSTART]) begin
                        state_q    <= ST_WRITE;
                        timerStart <= 1'b1;
                        timerAddr  <= memIdx;
                        timerData  <= nvmDataReg;
                    end else if (nvmControlReg[`EEDAC_BIT_RDSTART]) begin
                        state_q <= ST_READ;
                        rdCnt_q <= 4'h0;
                    end
                end
                ST_READ: begin
                    rdCnt_q <= rdCnt_q + 4'h1;
                    if (rdCnt_q == RD_CYCLES[3:0]) begin
                        nvmDataReg <= mem[memIdx];
                        state_q    <= ST_IDLE;
                        nvmControlReg[`EEDAC_BIT_RDSTART] <= 1'b0;
                    end
                end
                ST_WRITE: begin
                    // wait for the timer to drop its previous done level
                    if (!doneSync) begin
                        state_q <= ST_WDONE;
                    end
                end
                ST_WDONE: begin
                    if (wrDone) begin
                        state_q <= ST_IDLE;
                        nvmControlReg[`EEDAC_BIT_WRSTART] <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            eepromIrqRequest <= 1'b0;
            mfIrqRequest     <= 1'b0;
            irqVector        <= 1'b0;
        end else begin
            irqVector <= 1'b0;
            if (wrDone) begin
                eepromIrqRequest <= 1'b1;
                mfIrqRequest     <= 1'b1;
            end else begin
                if (irqAck) begin
                    mfIrqRequest <= 1'b0;
                end
                if (eepromIrqClear) begin
                    eepromIrqRequest <= 1'b0;
                end
            end
            if (mfIrqRequest && eepromIrqRequest && eepromIrqEnable && mfIrqEnable &&
                globalIrqEnable && !stackFull && !irqAck) begin
                irqVector <= 1'b1;
            end
        end
    end
endmodule

// ---- shared/eedac_regs.vh ----
// register offsets, field positions and reset values for the data eeprom access controller
// Summary of operation
// - write completion sets eeprom request flag and multi-function request flag
// - vector branch only with global, eeprom, multi-function enables and stack not full
// - servicing clears only the multi-function flag; eeprom flag cleared by firmware
// - control register: read-permit at bit 1, read-start at bit 0
// - control register: write-permit at bit 3, write-start at bit 2
// - hardware clears write-start and read-start when cycle finishes
// - start bit without its permit bit has no effect
// - 64 bytes, 6-bit address, upper two address bits read zero
`ifndef EEDAC_REGS_VH
`define EEDAC_REGS_VH
`define EEDAC_ADDR_OFS      8'h00
`define EEDAC_DATA_OFS      8'h01
`define EEDAC_CTRL_OFS      8'h40
`define EEDAC_CTRL_BANK     2'h1
`define EEDAC_REG_BANK      2'h0
`define EEDAC_BIT_RDSTART   0
`define EEDAC_BIT_RDPERMIT  1
`define EEDAC_BIT_WRSTART   2
`define EEDAC_BIT_WRPERMIT  3
`define EEDAC_ADDR_W        6
`define EEDAC_DEPTH         64
`define EEDAC_RST_BYTE      8'h00
`define EEDAC_RST_CTRL      4'h0
`define EEDAC_RD_CYCLES     2
`endif

// ---- rtl/eedac_sync.v ----
// three-stage synchroniser for the asynchronous write timer done level
`timescale 1ns/1ps
module eedac_sync (
    input  wire ref_clk,
    input  wire rst,
    input  wire asyncIn,
    output reg  syncOut
);
    reg stage1Q;
    reg stage2Q;
    reg stage3Q;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stage1Q <= 1'b0;
            stage2Q <= 1'b0;
            stage3Q <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            stage1Q <= asyncIn;
            stage2Q <= stage1Q;
            stage3Q <= stage2Q;
            // change accepted only once stages two and three agree
            if (stage2Q == stage3Q) begin
                syncOut <= stage3Q;
            end
        end
    end
endmodule

// ---- tb/eedac_timer_model.sv ----
// behavioural asynchronous write timer on the far side of the controller
`timescale 1ns/1ps
module eedac_timer_model (
    input  wire timerStart,
    input  wire slowMode,
    output reg  timerDone
);
    initial timerDone = 1'b0;
    // delays off the 25 ns grid so the done edge is unrelated to ref_clk
    always @(posedge timerStart) begin
        timerDone = 1'b0;
        #(slowMode ? 913.0 : 137.0);
        timerDone = 1'b1;
    end
endmodule

// ---- tb/eedac_properties.sv ----
// concurrent checks on the data eeprom access controller ports
`timescale 1ns/1ps
module eedac_properties (
    input wire       ref_clk,
    input wire       rst,
    input wire       timerStart,
    input wire       timerDone,
    input wire       irqVector,
    input wire       irqAck,
    input wire       eepromIrqClear,
    input wire       eepromIrqEnable,
    input wire       mfIrqEnable,
    input wire       globalIrqEnable,
    input wire       stackFull,
    input wire       eepromIrqRequest,
    input wire       mfIrqRequest,
    input wire [7:0] nvmAddressReg,
    input wire [7:0] nvmControlReg
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    addr_upper_zero_a: assert property (nvmAddressReg[7:6] == 2'h0)
        else $error("address upper bits set");
    wr_needs_permit_a: assert property ($rose(nvmControlReg[2]) |-> $past(nvmControlReg[3]))
        else $error("write start without permit");
    rd_needs_permit_a: assert property ($rose(nvmControlReg[0]) |-> $past(nvmControlReg[1]))
        else $error("read start without permit");
    write_launch_a: assert property ($rose(nvmControlReg[2]) |-> ##[0:2] timerStart)
        else $error("write timer not started");
    read_finish_a: assert property ($rose(nvmControlReg[0]) |-> ##[3:5] !nvmControlReg[0])
        else $error("read start not cleared in time");
    flags_together_a: assert property ($fell(nvmControlReg[2]) && !$past(rst) |-> eepromIrqRequest && mfIrqRequest)
        else $error("write end without both flags");
    done_synced_a: assert property ($fell(nvmControlReg[2]) && !$past(rst) |-> $past(timerDone, 3))
        else $error("write end before done settled");
    vector_gate_a: assert property (irqVector |->
        $past(mfIrqRequest && eepromIrqEnable && mfIrqEnable && globalIrqEnable && !stackFull))
        else $error("vector without enables");
    ack_keeps_flag_a: assert property (irqAck && eepromIrqRequest && !eepromIrqClear && !nvmControlReg[2] |=>
        eepromIrqRequest && !mfIrqRequest)
        else $error("service cleared wrong flag");
    cover property ($fell(nvmControlReg[2]));
    cover property ($fell(nvmControlReg[0]));
    cover property (irqVector);
endmodule
bind eedac_ctrl eedac_properties chk (.ref_clk(ref_clk), .rst(rst), .timerStart(timerStart), .timerDone(timerDone),
    .irqVector(irqVector), .irqAck(irqAck), .eepromIrqClear(eepromIrqClear), .eepromIrqEnable(eepromIrqEnable),
    .mfIrqEnable(mfIrqEnable), .globalIrqEnable(globalIrqEnable), .stackFull(stackFull),
    .eepromIrqRequest(eepromIrqRequest), .mfIrqRequest(mfIrqRequest), .nvmAddressReg(nvmAddressReg),
    .nvmControlReg(nvmControlReg));

// ---- tb/testbench.sv ----
// self-checking bench for the data eeprom access controller
`timescale 1ns/1ps
`define CHK(g, e) begin check_count = check_count + 1; if ((g) !== (e)) begin \
    mismatches = mismatches + 1; $display("[ERR] %0t got %h want %h", $time, g, e); end end
module testbench;
    reg        ref_clk, rst, cpuWrEn, stackFull, irqAck, eepromIrqClear, slowMode;
    reg        eepromIrqEnable, mfIrqEnable, globalIrqEnable;
    reg  [7:0] cpuAddr, cpuWrData;
    reg  [1:0] bankSelect;
    wire [7:0] nvmAddressReg, nvmDataReg, nvmControlReg, timerData;
    wire [5:0] timerAddr;
    wire       timerStart, timerDone, eepromIrqRequest, mfIrqRequest, irqVector;
    integer    mismatches, check_count, cycles = 0;
    eedac_ctrl dut (.ref_clk(ref_clk), .rst(rst), .cpuWrEn(cpuWrEn), .cpuAddr(cpuAddr), .bankSelect(bankSelect),
        .cpuWrData(cpuWrData), .nvmAddressReg(nvmAddressReg), .nvmDataReg(nvmDataReg), .nvmControlReg(nvmControlReg),
        .timerStart(timerStart), .timerAddr(timerAddr), .timerData(timerData), .timerDone(timerDone),
        .eepromIrqEnable(eepromIrqEnable), .mfIrqEnable(mfIrqEnable), .globalIrqEnable(globalIrqEnable),
        .stackFull(stackFull), .irqAck(irqAck), .eepromIrqClear(eepromIrqClear),
        .eepromIrqRequest(eepromIrqRequest), .mfIrqRequest(mfIrqRequest), .irqVector(irqVector));
    eedac_timer_model timer (.timerStart(timerStart), .slowMode(slowMode), .timerDone(timerDone));
    ////////////////////////////////////////////////////////////////////////
    task close_out;
        begin
            if (mismatches == 0 && check_count > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask
    task wr(input [7:0] a, input [1:0] b, input [7:0] d);
        begin
            cpuAddr = a;
            bankSelect = b;
            cpuWrData = d;
            cpuWrEn = 1'b1;
            @(posedge ref_clk) #2;
            cpuWrEn = 1'b0;
            bankSelect = 2'h0;
            @(posedge ref_clk) #2;
        end
    endtask
    task poll(input integer b);
        integer n;
        begin
            n = 0;
            while (nvmControlReg[b] === 1'b1 && n < 200) begin
                @(posedge ref_clk) #2;
                n = n + 1;
            end
            `CHK(nvmControlReg[b], 1'b0)
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_refuse;
        begin
            wr(8'h40, 2'h0, 8'h08);
            `CHK(nvmControlReg, 8'h00)
            wr(8'h40, 2'h1, 8'h01);
            `CHK(nvmControlReg, 8'h00)
            wr(8'h40, 2'h1, 8'h04);
            `CHK({nvmControlReg, timerStart}, 9'h000)
        end
    endtask
    task t_write(input [7:0] a, input [7:0] d, input s);
        begin
            slowMode = s;
            globalIrqEnable = 1'b0;
            wr(8'h00, 2'h0, a);
            wr(8'h01, 2'h0, d);
            wr(8'h40, 2'h1, 8'h08);
            wr(8'h40, 2'h1, 8'h0C);
            globalIrqEnable = 1'b1;
            `CHK(nvmControlReg, 8'h0C)
            poll(2);
            `CHK(({nvmAddressReg, timerAddr, timerData}), ({2'h0, a[5:0], a[5:0], d}))
            `CHK(({eepromIrqRequest, mfIrqRequest}), 2'h3)
            wr(8'h40, 2'h1, 8'h00);
        end
    endtask
    task t_read(input [7:0] a, input [7:0] d);
        begin
            wr(8'h00, 2'h0, a);
            wr(8'h40, 2'h1, 8'h02);
            wr(8'h40, 2'h1, 8'h03);
            `CHK(nvmControlReg, 8'h03)
            poll(0);
            `CHK(nvmDataReg, d)
            wr(8'h40, 2'h1, 8'h00);
        end
    endtask
    task t_irq;
        begin
            {stackFull, eepromIrqEnable, mfIrqEnable, globalIrqEnable} = 4'hF;
            repeat (3) @(posedge ref_clk) #2;
            `CHK(irqVector, 1'b0)
            stackFull = 1'b0;
            repeat (2) @(posedge ref_clk) #2;
            `CHK(irqVector, 1'b1)
            irqAck = 1'b1;
            @(posedge ref_clk) #2;
            irqAck = 1'b0;
            @(posedge ref_clk) #2;
            `CHK(({eepromIrqRequest, mfIrqRequest}), 2'h2)
            eepromIrqClear = 1'b1;
            @(posedge ref_clk) #2;
            eepromIrqClear = 1'b0;
            @(posedge ref_clk) #2;
            `CHK(eepromIrqRequest, 1'b0)
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            mismatches = mismatches + 1;
            close_out;
        end
    end
    initial begin
        {rst, cpuWrEn, stackFull, irqAck, eepromIrqClear, slowMode} = 6'h20;
        {eepromIrqEnable, mfIrqEnable, globalIrqEnable} = 3'h0;
        {cpuAddr, cpuWrData, bankSelect} = 18'h0;
        mismatches = 0;
        check_count = 0;
        repeat (4) @(posedge ref_clk) #2;
        rst = 1'b0;
        `CHK(({nvmAddressReg, nvmDataReg, nvmControlReg}), 24'h0)
        t_refuse;
        t_write(8'hFF, 8'hA5, 1'b0);
        t_irq;
        t_write(8'h00, 8'h5A, 1'b1);
        t_read(8'h3F, 8'hA5);
        t_read(8'h00, 8'h5A);
        close_out;
    end
endmodule
